//--- shared/ccm_pkg.sv
// Package of constants and types for the configuration console menu.
package ccm_pkg;

    // ------------------------------------------------------------
    // Characters received from the terminal
    // ------------------------------------------------------------
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_RET  = 8'h0D;
    localparam logic [7:0] CH_ESC  = 8'h1B;

    // ------------------------------------------------------------
    // Reset values of the settings
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_LINK   = 8'h01;
    localparam logic [16:0] RST_BAUD   = 17'h02580;
    localparam logic        RST_STOP2  = 1'b0;
    localparam logic [2:0]  RST_PARITY = 3'h0;
    localparam logic [7:0]  RST_FUNC   = 8'hA0;
    localparam logic        RST_TERM   = 1'b1;
    localparam logic [15:0] RST_INV    = 16'h0000;
    localparam logic        RST_PAIR   = 1'b0;
    localparam logic [15:0] RST_FILT   = 16'h0064;

    // ------------------------------------------------------------
    // Entry limits
    // ------------------------------------------------------------
    localparam logic [16:0] LINK_MAX   = 17'h000F7;
    localparam logic [16:0] FUNC_MAX   = 17'h000FF;
    localparam logic [16:0] FILT_MAX   = 17'h0EA60;
    localparam logic [16:0] PIN_MAX    = 17'h00010;
    localparam logic [16:0] PAR_MAX    = 17'h00004;
    localparam logic [16:0] BAUD_MAX   = 17'h1FFFF;
    localparam logic [16:0] ENTRY_CAP  = 17'h03333;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Screens and edited fields
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SCR_IDLE = 4'h0, SCR_MAIN = 4'h1, SCR_COMM = 4'h2,
        SCR_ADDR = 4'h3, SCR_TERM = 4'h4, SCR_INV  = 4'h5,
        SCR_INCF = 4'h6, SCR_DFLT = 4'h7, SCR_FWUP = 4'h8,
        SCR_DIAG = 4'h9, SCR_EDIT = 4'hA, SCR_SIM  = 4'hB
    } ccm_screen_e;

    typedef enum logic [2:0] {
        FLD_LINK = 3'h0, FLD_BAUD = 3'h1, FLD_PAR  = 3'h2,
        FLD_FUNC = 3'h3, FLD_PIN  = 3'h4, FLD_FILT = 3'h5
    } ccm_field_e;

endpackage : ccm_pkg

//--- rtl/ccm_console.sv
// Menu-driven configuration console with input filter and diagnostics.
// Functional notes
// RL1 - New connection shows main menu immediately; code skips this while on the simulator screen
// RL2 - Single digit selects screen or action
// RL3 - Edit: return commits, escape discards value
// RL4 - Host sends exit digit before disconnecting
// RL5 - Defaults need confirm digit one; zero cancels
// RL6 - After reconnect any character shows main; code ignores characters on the simulator screen
// RL7 - Link address accepts 1 to 247
// RL8 - Frame 8+1 or 8+2, default 9600
// RL9 - Parity none, odd, even, mark, space
// RL10 - Function-type address 1 to 255, default 160
// RL11 - Termination single bit, default on
// RL12 - Per-pin inversion chosen by pin number
// RL13 - Paired inputs still inverted per pin
// RL14 - Sixteen single inputs or eight pairs; code only stores pair_mode, which no input logic uses
// RL15 - Glitch filter 1 to 60000 ms
// RL16 - Diagnostics shows states, refresh, simulator
// RL17 - Simulator closes RS485 until restart
// RL18 - Unmatched characters are ignored
module ccm_console
    import ccm_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // Character stream from the virtual serial port.
    input  wire logic        conn_open,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_char,
    // Raw input pins.
    input  wire logic [15:0] din_pin,
    // Screen presentation.
    output logic [3:0]       screen,
    output logic             show,
    output logic [16:0]      entry,
    // Settings.
    output logic [7:0]       link_addr,
    output logic [16:0]      baud,
    output logic             stop_two,
    output logic [2:0]       parity,
    output logic [7:0]       func_addr,
    output logic             term_en,
    output logic [15:0]      invert,
    output logic             pair_mode,
    output logic [15:0]      filter_ms,
    // Mode and state.
    output logic             sim_mode,
    output logic             rs485_en,
    output logic             fw_upgrade,
    output logic [15:0]      din_state
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // True when the character is an ASCII digit.
    function automatic logic is_dig(input logic [7:0] c);
        return (c >= CH_ZERO) && (c <= CH_NINE);
    endfunction : is_dig

    // True when the character is the given digit.
    function automatic logic key(input logic [7:0] c,
                                 input logic [3:0] d);
        return c == (CH_ZERO + {4'h0, d});
    endfunction : key

    // True when a value lies within lo and hi.
    function automatic logic in_rng(input logic [16:0] v,
                                    input logic [16:0] lo,
                                    input logic [16:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_rng

    // ------------------------------------------------------------
    // Menu and settings state
    // ------------------------------------------------------------
    ccm_screen_e scr, next_scr, ret_scr, next_ret_scr;
    ccm_field_e  fld, next_fld;
    logic        next_show, next_stop_two, next_term_en, next_pair;
    logic        next_sim, next_fw;
    logic [16:0] next_entry, next_baud;
    logic [7:0]  next_link, next_func;
    logic [2:0]  next_parity;
    logic [15:0] next_invert, next_filter;
    logic [3:0]  dv;
    logic        go;

    assign dv = rx_char[3:0];
    assign go = rx_valid && (scr != SCR_SIM);

    // Next-state logic of the menu walker.
    always_comb begin
        next_scr      = scr;
        next_ret_scr  = ret_scr;
        next_fld      = fld;
        next_show     = 1'b0;
        next_entry    = entry;
        next_link     = link_addr;
        next_baud     = baud;
        next_stop_two = stop_two;
        next_parity   = parity;
        next_func     = func_addr;
        next_term_en  = term_en;
        next_invert   = invert;
        next_pair     = pair_mode;
        next_filter   = filter_ms;
        next_sim      = sim_mode;
        next_fw       = fw_upgrade;
        if (conn_open && scr != SCR_SIM) begin
            next_scr  = SCR_MAIN;                  // see RL1
            next_show = 1'b1;
        end else if (go) begin
            next_show = 1'b1;
            case (scr)
                SCR_IDLE: next_scr = SCR_MAIN;     // see RL6
                SCR_MAIN: begin                    // see RL2
                    if (key(rx_char, 4'h1)) begin
                        next_scr     = SCR_EDIT;
                        next_fld     = FLD_LINK;
                        next_ret_scr = SCR_MAIN;
                        next_entry   = '0;
                    end else if (key(rx_char, 4'h2)) next_scr = SCR_COMM;
                    else if (key(rx_char, 4'h3)) next_scr = SCR_ADDR;
                    else if (key(rx_char, 4'h4)) next_scr = SCR_TERM;
                    else if (key(rx_char, 4'h5)) next_scr = SCR_INV;
                    else if (key(rx_char, 4'h6)) next_scr = SCR_INCF;
                    else if (key(rx_char, 4'h7)) next_scr = SCR_DFLT;
                    else if (key(rx_char, 4'h8)) next_scr = SCR_FWUP;
                    else if (key(rx_char, 4'h9)) next_scr = SCR_DIAG;
                    else if (key(rx_char, 4'h0)) next_scr = SCR_IDLE;
                    else next_show = 1'b0;         // see RL18
                end
                SCR_COMM: begin
                    next_ret_scr = SCR_COMM;
                    next_entry   = '0;
                    if (key(rx_char, 4'h1)) next_stop_two = 1'b0; // see RL8
                    else if (key(rx_char, 4'h2)) next_stop_two = 1'b1;
                    else if (key(rx_char, 4'h3)) begin
                        next_scr = SCR_EDIT;       // see RL3
                        next_fld = FLD_BAUD;
                    end else if (key(rx_char, 4'h4)) begin
                        next_scr = SCR_EDIT;       // see RL9
                        next_fld = FLD_PAR;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;         // see RL18
                end
                SCR_ADDR: begin
                    next_ret_scr = SCR_ADDR;
                    next_entry   = '0;
                    if (key(rx_char, 4'h1)) begin
                        next_scr = SCR_EDIT;       // see RL10
                        next_fld = FLD_FUNC;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_TERM: begin
                    if (key(rx_char, 4'h1)) next_term_en = ~term_en; // see RL11
                    else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_INV: begin
                    next_ret_scr = SCR_INV;
                    next_entry   = '0;
                    if (key(rx_char, 4'h3)) begin
                        next_scr = SCR_EDIT;       // see RL12
                        next_fld = FLD_PIN;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_INCF: begin
                    next_ret_scr = SCR_INCF;
                    next_entry   = '0;
                    if (key(rx_char, 4'h1)) next_pair = ~pair_mode; // see RL14
                    else if (key(rx_char, 4'h2)) begin
                        next_scr = SCR_EDIT;       // see RL15
                        next_fld = FLD_FILT;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_DFLT: begin
                    if (key(rx_char, 4'h1)) begin  // see RL5
                        next_scr      = SCR_MAIN;
                        next_link     = RST_LINK;
                        next_baud     = RST_BAUD;
                        next_stop_two = RST_STOP2;
                        next_parity   = RST_PARITY;
                        next_func     = RST_FUNC;
                        next_term_en  = RST_TERM;
                        next_invert   = RST_INV;
                        next_pair     = RST_PAIR;
                        next_filter   = RST_FILT;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_FWUP: begin
                    if (key(rx_char, 4'h1)) next_fw = 1'b1;
                    else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_DIAG: begin
                    if (key(rx_char, 4'h1)) next_scr = SCR_DIAG; // see RL16
                    else if (key(rx_char, 4'h9)) begin
                        next_scr = SCR_SIM;        // see RL17
                        next_sim = 1'b1;
                    end else if (key(rx_char, 4'h0)) next_scr = SCR_MAIN;
                    else next_show = 1'b0;
                end
                SCR_EDIT: begin
                    if (is_dig(rx_char)) begin
                        if (entry < ENTRY_CAP)
                            next_entry = 17'((entry << 3) + (entry << 1)
                                             + {13'h0, dv});
                    end else if (rx_char == CH_ESC) begin
                        next_scr = ret_scr;        // see RL3
                    end else if (rx_char == CH_RET) begin
                        next_scr = ret_scr;        // see RL3
                        case (fld)
                            FLD_LINK: if (in_rng(entry, 17'h1, LINK_MAX))
                                next_link = entry[7:0];     // see RL7
                            FLD_BAUD: if (in_rng(entry, 17'h1, BAUD_MAX))
                                next_baud = entry;
                            FLD_PAR: if (in_rng(entry, 17'h0, PAR_MAX))
                                next_parity = entry[2:0];   // see RL9
                            FLD_FUNC: if (in_rng(entry, 17'h1, FUNC_MAX))
                                next_func = entry[7:0];     // see RL10
                            FLD_PIN: if (in_rng(entry, 17'h1, PIN_MAX))
                                next_invert[4'(entry - 17'h1)] =
                                    ~invert[4'(entry - 17'h1)]; // see RL12
                            FLD_FILT: if (in_rng(entry, 17'h1, FILT_MAX))
                                next_filter = entry[15:0];  // see RL15
                            default: next_scr = ret_scr;
                        endcase
                    end else begin
                        next_show = 1'b0;          // see RL18
                    end
                end
                default: next_show = 1'b0;
            endcase
        end
    end

    // Registers of the menu walker and the settings.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scr        <= SCR_IDLE;
            ret_scr    <= SCR_MAIN;
            fld        <= FLD_LINK;
            show       <= 1'b0;
            entry      <= '0;
            link_addr  <= RST_LINK;
            baud       <= RST_BAUD;
            stop_two   <= RST_STOP2;
            parity     <= RST_PARITY;
            func_addr  <= RST_FUNC;
            term_en    <= RST_TERM;
            invert     <= RST_INV;
            pair_mode  <= RST_PAIR;
            filter_ms  <= RST_FILT;
            sim_mode   <= 1'b0;
            rs485_en   <= 1'b1;
            fw_upgrade <= 1'b0;
        end else if (ce) begin
            scr        <= next_scr;
            ret_scr    <= next_ret_scr;
            fld        <= next_fld;
            show       <= next_show;
            entry      <= next_entry;
            link_addr  <= next_link;
            baud       <= next_baud;
            stop_two   <= next_stop_two;
            parity     <= next_parity;
            func_addr  <= next_func;
            term_en    <= next_term_en;
            invert     <= next_invert;
            pair_mode  <= next_pair;
            filter_ms  <= next_filter;
            sim_mode   <= next_sim;
            rs485_en   <= ~next_sim;           // see RL17
            fw_upgrade <= next_fw;
        end
    end

    assign screen = scr;

    // ------------------------------------------------------------
    // Input synchroniser and glitch filter
    // ------------------------------------------------------------
    logic [15:0] sync1, sync2, stable, next_stable;
    logic [15:0] cnt [16];
    logic [15:0] next_cnt [16];
    logic [15:0] next_state;
    logic [15:0] tick_cnt, next_tick_cnt;
    logic        tick;

    assign tick = (tick_cnt == 16'(MS_CYC - 1));

    // Per-pin stability counters advance once per millisecond.
    always_comb begin
        next_tick_cnt = tick ? '0 : tick_cnt + 16'h1;
        next_stable   = stable;
        for (int i = 0; i < 16; i++) begin
            next_cnt[i] = cnt[i];
            if (sync2[i] == stable[i]) begin
                next_cnt[i] = '0;
            end else if (tick) begin
                if (cnt[i] + 16'h1 >= filter_ms) begin
                    next_stable[i] = sync2[i];     // see RL15
                    next_cnt[i]    = '0;
                end else begin
                    next_cnt[i] = cnt[i] + 16'h1;
                end
            end
        end
        next_state = next_stable ^ invert;         // see RL12
    end

    // Registers of the synchroniser, filter and reported state.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1     <= '0;
            sync2     <= '0;
            stable    <= '0;
            tick_cnt  <= '0;
            din_state <= '0;
            for (int i = 0; i < 16; i++) cnt[i] <= '0;
        end else if (ce) begin
            sync1     <= din_pin;
            sync2     <= sync1;
            stable    <= next_stable;
            tick_cnt  <= next_tick_cnt;
            din_state <= next_state;           // see RL16
            for (int i = 0; i < 16; i++) cnt[i] <= next_cnt[i];
        end
    end

endmodule : ccm_console

//--- tb/ccm_host.sv
// Host terminal model that types characters into the console.
module ccm_host
    import ccm_pkg::*;
(
    // Clock.
    input  wire logic       sys_clk,
    // Character stream towards the console.
    output logic            conn_open,
    output logic            rx_valid,
    output logic [7:0]      rx_char
);
    timeunit 1ns;
    timeprecision 1ns;

    // Quiet lines at time zero.
    initial begin
        conn_open = 1'b0;
        rx_valid  = 1'b0;
        rx_char   = 8'h00;
    end

    // Opens a terminal session with a one-cycle pulse.
    task automatic connect();
        @(negedge sys_clk);
        conn_open = 1'b1;
        @(negedge sys_clk);
        conn_open = 1'b0;
    endtask : connect

    // One keystroke; the idle byte is inverted so it is never stale.
    task automatic key(input logic [7:0] c);
        @(negedge sys_clk);
        rx_valid = 1'b1;
        rx_char  = c;
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_char  = ~c;
    endtask : key

    // Types a decimal value, then saves it or cancels it.
    task automatic number(input int v, input bit save);
        string s;
        s = $sformatf("%0d", v);
        foreach (s[i]) key(s[i]);
        key(save ? CH_RET : CH_ESC);
    endtask : number

    // Inverts one pin; pairs are still set pin by pin.
    task automatic pin_invert(input int pin);
        key("3");
        number(pin, 1'b1);
    endtask : pin_invert

    // Leaves the console before the session is dropped.
    task automatic leave();
        key(CH_ZERO);
    endtask : leave
endmodule : ccm_host

//--- tb/ccm_console_props.sv
// Concurrent checks on the ports of the configuration console.
module ccm_console_props
    import ccm_pkg::*;
#(
    parameter int MS_CYC = MS_CYCLES
) (
    // Clock, reset and enable.
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        ce,
    // Character stream and raw input pins.
    input wire logic        conn_open,
    input wire logic        rx_valid,
    input wire logic [7:0]  rx_char,
    input wire logic [15:0] din_pin,
    // Screen and settings.
    input wire logic [3:0]  screen,
    input wire logic        show,
    input wire logic [16:0] entry,
    input wire logic [7:0]  link_addr,
    input wire logic [16:0] baud,
    input wire logic        stop_two,
    input wire logic [2:0]  parity,
    input wire logic [7:0]  func_addr,
    input wire logic        term_en,
    input wire logic [15:0] invert,
    input wire logic        pair_mode,
    input wire logic [15:0] filter_ms,
    // Mode and state.
    input wire logic        sim_mode,
    input wire logic        rs485_en,
    input wire logic        fw_upgrade,
    input wire logic [15:0] din_state
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // A character taken this cycle, and the redraw that answers it.
    sequence s_take(logic [7:0] c);
        ce && rx_valid && !conn_open && rx_char == c;
    endsequence
    sequence s_drawn(logic [3:0] s);
        show && screen == s;
    endsequence

    a_conn_main: assert property (ce && conn_open && screen != SCR_SIM
        |=> s_drawn(SCR_MAIN)) else $error("no main menu on connect");
    a_idle_any_key: assert property (ce && rx_valid && !conn_open
        && screen == SCR_IDLE |=> s_drawn(SCR_MAIN))
        else $error("idle console ignored a key");
    a_quiet_no_show: assert property (!(ce && (rx_valid || conn_open))
        |=> !show) else $error("redraw without a key");
    a_hold_no_key: assert property (!(ce && rx_valid) |=> $stable(baud)
        && $stable(link_addr) && $stable(invert) && $stable(filter_ms))
        else $error("setting changed without a key");
    a_dflt_cancel: assert property (screen == SCR_DFLT ##0 s_take(CH_ZERO)
        |=> $stable(link_addr) && $stable(baud) && $stable(invert))
        else $error("defaults applied on cancel");
    a_diag_sim: assert property (screen == SCR_DIAG ##0 s_take(CH_NINE)
        |=> sim_mode && screen == SCR_SIM) else $error("no simulator");
    a_sim_sticks: assert property (sim_mode |=> sim_mode && !rs485_en
        && screen == SCR_SIM) else $error("simulator mode left");
    a_rs485_mirror: assert property (rs485_en != sim_mode)
        else $error("line enable wrong");
    a_link_range: assert property (link_addr inside {[1:247]})
        else $error("link address out of range");
    a_func_range: assert property (func_addr != 8'h00)
        else $error("function address zero");
    a_filter_range: assert property (filter_ms inside {[1:60000]})
        else $error("filter time out of range");
    a_parity_code: assert property (parity <= 3'h4)
        else $error("parity code unknown");
endmodule : ccm_console_props

bind ccm_console ccm_console_props #(.MS_CYC(MS_CYC)) u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .conn_open(conn_open),
    .rx_valid(rx_valid), .rx_char(rx_char), .din_pin(din_pin),
    .screen(screen), .show(show), .entry(entry), .link_addr(link_addr),
    .baud(baud), .stop_two(stop_two), .parity(parity),
    .func_addr(func_addr), .term_en(term_en), .invert(invert),
    .pair_mode(pair_mode), .filter_ms(filter_ms), .sim_mode(sim_mode),
    .rs485_en(rs485_en), .fw_upgrade(fw_upgrade), .din_state(din_state)
);

//--- tb/ccm_console_bench.sv
// Self-checking bench for the configuration console.
module ccm_console_bench
    import ccm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MSC = 4;
    logic        sys_clk, sys_rst, ce, conn_open, rx_valid, show, stop_two;
    logic        term_en, pair_mode, sim_mode, rs485_en, fw_upgrade;
    logic [7:0]  rx_char, link_addr, func_addr;
    logic [15:0] din_pin, invert, filter_ms, din_state;
    logic [3:0]  screen;
    logic [16:0] entry, baud;
    logic [2:0]  parity;
    int          e_link, e_baud, e_stop, e_par, e_func, e_term, e_inv;
    int          e_pair, e_filt, err_count, check_count, seed;

    ccm_console #(.MS_CYC(MSC)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .conn_open(conn_open),
        .rx_valid(rx_valid), .rx_char(rx_char), .din_pin(din_pin),
        .screen(screen), .show(show), .entry(entry), .link_addr(link_addr),
        .baud(baud), .stop_two(stop_two), .parity(parity),
        .func_addr(func_addr), .term_en(term_en), .invert(invert),
        .pair_mode(pair_mode), .filter_ms(filter_ms), .sim_mode(sim_mode),
        .rs485_en(rs485_en), .fw_upgrade(fw_upgrade), .din_state(din_state));
    ccm_host host (.sys_clk(sys_clk), .conn_open(conn_open),
        .rx_valid(rx_valid), .rx_char(rx_char));

    // ----------------------------------------
    // Clock, model and checking helpers
    // ----------------------------------------
    // Free-running 20 MHz clock.
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;

    // Factory settings of the model.
    task automatic dflt();
        e_link = 1;
        e_baud = 9600;
        e_stop = 0;
        e_par  = 0;
        e_func = 160;
        e_term = 1;
        e_inv  = 0;
        e_pair = 0;
        e_filt = 100;
    endtask : dflt

    // Counts one comparison and reports a mismatch.
    task automatic chk(input logic [16:0] got, input int exp);
        check_count++;
        if (got !== 17'(exp)) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                17'(exp));
        end
    endtask : chk

    // Compares every setting with the model.
    task automatic chk_all();
        chk(17'(link_addr), e_link);
        chk(baud, e_baud);
        chk(17'(stop_two), e_stop);
        chk(17'(parity), e_par);
        chk(17'(func_addr), e_func);
        chk(17'(term_en), e_term);
        chk(17'(invert), e_inv);
        chk(17'(pair_mode), e_pair);
        chk(17'(filter_ms), e_filt);
    endtask : chk_all

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // Cuts a hang short after 20000 cycles.
    initial begin
        #1000000;
        err_count++;
        summarize();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        seed = 60562;
        err_count = 0;
        check_count = 0;
        sys_rst = 1'b1;
        ce = 1'b1;
        din_pin = 16'h0000;
        dflt();
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        chk_all();
        chk(17'({sim_mode, rs485_en, fw_upgrade, screen}), 'h20);
        host.connect();
        chk(17'({show, screen}), 'h11);
        host.key(CH_RET);
        chk(17'({show, screen}), 'h01);
        host.key("2");
        chk(17'({show, screen}), 'h12);
        host.key("2");
        e_stop = 1;
        chk_all();
        host.key("1");
        e_stop = 0;
        host.key("3");
        host.number(19200, 1'b1);
        e_baud = 19200;
        chk_all();
        host.key("3");
        host.number(4800, 1'b0);
        chk(entry, 4800);
        chk_all();
        for (int p = 4; p >= 0; p--) begin
            host.key("4");
            host.number(p, 1'b1);
            e_par = p;
            chk_all();
        end
        host.key("0");
        host.key("1");
        host.number(248, 1'b1);
        host.key("1");
        host.number(247, 1'b1);
        e_link = 247;
        chk_all();
        host.key("3");
        host.key("1");
        host.number(0, 1'b1);
        host.key("1");
        host.number(255, 1'b1);
        e_func = 255;
        host.key("0");
        host.key("4");
        host.key("1");
        e_term = 0;
        chk_all();
        host.key("0");
        host.key("5");
        host.pin_invert(16);
        host.pin_invert(3);
        host.pin_invert(17);
        e_inv = 'h8004;
        host.key("0");
        host.key("6");
        host.key("1");
        e_pair = 1;
        host.key("2");
        host.number(60001, 1'b1);
        host.key("2");
        host.number(2, 1'b1);
        e_filt = 2;
        chk_all();
        host.key("0");
        din_pin = 16'($random(seed));
        repeat (2) @(negedge sys_clk);
        chk(17'(din_state), e_inv);
        repeat (30) @(negedge sys_clk);
        chk(17'(din_state), int'(din_pin) ^ e_inv);
        // A two-cycle glitch is shorter than two filter ticks.
        din_pin = ~din_pin;
        repeat (2) @(negedge sys_clk);
        din_pin = ~din_pin;
        repeat (30) @(negedge sys_clk);
        chk(17'(din_state), int'(din_pin) ^ e_inv);
        // A key while the enable is low changes nothing.
        ce = 1'b0;
        host.key("1");
        chk(17'({show, screen}), 'h01);
        ce = 1'b1;
        host.key("6");
        chk(17'(screen), 6);
        host.key("0");
        host.key("7");
        host.key("0");
        chk_all();
        host.key("7");
        host.key("1");
        dflt();
        chk_all();
        host.key("8");
        host.key("1");
        chk(17'({fw_upgrade, screen}), 'h18);
        host.key("0");
        host.leave();
        chk(17'(screen), 0);
        host.key(8'($random(seed)));
        chk(17'({show, screen}), 'h11);
        host.key("9");
        host.key("1");
        chk(17'({show, screen}), 'h19);
        host.key("9");
        chk(17'({sim_mode, rs485_en, screen}), 'h2B);
        host.connect();
        host.key("0");
        chk(17'({show, sim_mode, rs485_en, screen}), 'h2B);
        summarize();
    end
endmodule : ccm_console_bench
